//--- logic/cle_loader.sv
// Serial configuration loader with frame check and error halt
// Operation
// (R1) Serial data taken one bit, LSB first
// (R2) Host sends each byte LSB first
// (R3) Check value computed per frame, compared
// (R4) Check mismatch halts, status held low
// (R5) Supply failure halts until reconfigured
// (R6) Active scheme restarts when supply recovers
// (R7) Memory resets its read-out on status low
// (R8) Passive host starts reconfiguration after error
// (R9) JTAG inputs kept stable during configuration
// (R10) After halt ignore bits until restart
`default_nettype none
module cle_loader
  import cle_pkg::*;
#(
  parameter int unsigned FRAME_BITS = cle_pkg::CLE_FRAME_BITS
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET,
  // Configuration pins
  input  wire logic DCLK_IN,
  input  wire logic DATA_IN,
  input  wire logic CONFIG_REQ_N,
  input  wire logic ACTIVE_SCHEME,
  input  wire logic SUPPLY_OK,
  // Status open-drain
  input  wire logic STATUS_IN,
  output logic      STATUS_OUT,
  output logic      STATUS_OE,
  // Byte output
  output logic [7:0] BYTE_DATA,
  output logic       BYTE_VALID,
  input  wire logic  BYTE_READY,
  // Flags
  output logic      CRC_ERROR,
  output logic      SUPPLY_ERROR,
  output logic      FRAME_DONE,
  output logic      LOADING
);
  import cle_pkg::*;

  typedef struct packed {
    logic [1:0]  sync_clk;
    logic [1:0]  sync_dat;
    logic [1:0]  sync_req;
    logic [1:0]  sync_sup;
    logic [1:0]  sync_sts;
    logic [1:0]  sync_act;
    logic        clk_prev;
    logic        req_prev;
    cle_state_t  state;
    logic [15:0] crc;
    logic [15:0] rx_crc;
    logic [15:0] bit_cnt;
    logic [4:0]  chk_cnt;
    logic [2:0]  sh_cnt;
    logic [7:0]  sh;
    logic [7:0]  buf0;
    logic [7:0]  buf1;
    logic [1:0]  fill;
    logic        crc_err;
    logic        sup_err;
    logic        frame_done;
    logic        drop;
  } cle_regs_t;

  cle_regs_t r_reg;
  cle_regs_t r_next;

  logic dclk_rise;
  logic din;
  logic req_fall;
  logic sup_ok;
  logic fb;
  logic push;
  logic pop;

  assign dclk_rise = r_reg.sync_clk[1] & ~r_reg.clk_prev;
  assign din       = r_reg.sync_dat[1];
  assign req_fall  = r_reg.req_prev & ~r_reg.sync_req[1];
  assign sup_ok    = r_reg.sync_sup[1];
  assign fb        = din ^ r_reg.crc[15];
  assign pop       = (r_reg.fill != 2'd0) && BYTE_READY;

  // Next-state logic of the whole loader
  always_comb begin
    r_next            = r_reg;
    push              = 1'b0;

    // Pin synchronisers and edge history
    r_next.sync_clk   = {r_reg.sync_clk[0], DCLK_IN};
    r_next.sync_dat   = {r_reg.sync_dat[0], DATA_IN};
    r_next.sync_req   = {r_reg.sync_req[0], CONFIG_REQ_N};
    r_next.sync_sup   = {r_reg.sync_sup[0], SUPPLY_OK};
    r_next.sync_sts   = {r_reg.sync_sts[0], STATUS_IN};
    r_next.sync_act   = {r_reg.sync_act[0], ACTIVE_SCHEME};
    r_next.clk_prev   = r_reg.sync_clk[1];
    r_next.req_prev   = r_reg.sync_req[1];
    r_next.frame_done = 1'b0;

    // Output buffer, pop side
    if (pop) begin
      r_next.buf0 = r_reg.buf1;
      r_next.fill = r_reg.fill - 2'd1;
    end

    // Load sequencer
    case (r_reg.state)
      CLE_IDLE: begin
        if (req_fall) begin
          r_next.state   = CLE_DATA;
          r_next.crc     = CLE_CRC_INIT;
          r_next.bit_cnt = 16'd0;
          r_next.sh_cnt  = 3'd0;
        end
      end
      CLE_DATA: begin
        if (dclk_rise) begin
          r_next.crc = {r_reg.crc[14:0], 1'b0} ^ (fb ? CLE_CRC_POLY : 16'h0000); // (R3)
          r_next.sh  = {din, r_reg.sh[7:1]}; // (R1)
          r_next.sh_cnt = r_reg.sh_cnt + 3'd1;
          if (r_reg.sh_cnt == 3'd7) begin
            push = 1'b1;
          end
          r_next.bit_cnt = r_reg.bit_cnt + 16'd1;
          if (r_reg.bit_cnt == 16'(FRAME_BITS - 1)) begin
            r_next.state   = CLE_CHECK;
            r_next.chk_cnt = 5'd0;
          end
        end
      end
      CLE_CHECK: begin
        if (dclk_rise) begin
          r_next.rx_crc  = {din, r_reg.rx_crc[15:1]}; // (R3)
          r_next.chk_cnt = r_reg.chk_cnt + 5'd1;
          if (r_reg.chk_cnt == 5'(CLE_CRC_W - 1)) begin
            if ({din, r_reg.rx_crc[15:1]} != r_reg.crc) begin
              r_next.state   = CLE_HALT; // (R4)
              r_next.crc_err = 1'b1;
            end else begin
              r_next.state      = CLE_DATA;
              r_next.frame_done = 1'b1;
              r_next.crc        = CLE_CRC_INIT;
              r_next.bit_cnt    = 16'd0;
            end
          end
        end
      end
      CLE_HALT: begin
        if (req_fall) begin // (R10)
          r_next.state   = CLE_DATA;
          r_next.crc_err = 1'b0;
          r_next.sup_err = 1'b0;
          r_next.crc     = CLE_CRC_INIT;
          r_next.bit_cnt = 16'd0;
          r_next.sh_cnt  = 3'd0;
        end
      end
      CLE_SUPPLY: begin
        if (sup_ok && r_reg.sync_act[1] && r_reg.sync_req[1]) begin // (R6)
          r_next.state   = CLE_DATA;
          r_next.sup_err = 1'b0;
          r_next.crc     = CLE_CRC_INIT;
          r_next.bit_cnt = 16'd0;
          r_next.sh_cnt  = 3'd0;
        end else if (sup_ok) begin
          r_next.state = CLE_HALT; // (R5)
        end
      end
      default: begin
        r_next.state = CLE_IDLE;
      end
    endcase

    // Supply failure overrides every state
    if (!sup_ok) begin
      r_next.state   = CLE_SUPPLY; // (R5)
      r_next.sup_err = 1'b1;
      push           = 1'b0;
    end

    // Output buffer, push side; a byte is lost when both entries stay full, or when supply fails as it completes
    r_next.drop = push && (r_reg.fill == 2'(CLE_BUF_DEPTH)) && !pop;
    if (push && !r_next.drop) begin
      if (r_next.fill == 2'd0) begin
        r_next.buf0 = r_next.sh;
      end else begin
        r_next.buf1 = r_next.sh;
      end
      r_next.fill = r_next.fill + 2'd1;
    end
  end


  // State register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      r_reg          <= '0;
      r_reg.crc      <= CLE_CRC_INIT;
      r_reg.state    <= CLE_IDLE;
      // Synchronisers start at the idle pin levels, so release gives no false event
      r_reg.sync_req <= 2'b11;
      r_reg.req_prev <= 1'b1;
      r_reg.sync_sup <= 2'b11;
      r_reg.sync_sts <= 2'b11;
    end else begin
      r_reg <= r_next;
    end
  end


  // Open-drain status: drive low on halt
  assign STATUS_OUT   = 1'b0;
  assign STATUS_OE    = (r_reg.state == CLE_HALT) || (r_reg.state == CLE_SUPPLY); // (R4)
  assign BYTE_DATA    = r_reg.buf0;
  assign BYTE_VALID   = r_reg.fill != 2'd0;
  assign CRC_ERROR    = r_reg.crc_err;
  assign SUPPLY_ERROR = r_reg.sup_err;
  assign FRAME_DONE   = r_reg.frame_done;
  assign LOADING      = (r_reg.state == CLE_DATA) || (r_reg.state == CLE_CHECK);
endmodule
`default_nettype wire

//--- logic/cle_pkg.sv
// Package of constants and types for the configuration load error handler
`default_nettype none
package cle_pkg;
  localparam int unsigned CLE_CRC_W      = 16;
  localparam int unsigned CLE_FRAME_BITS = 64;
  localparam logic [15:0] CLE_CRC_POLY   = 16'h8005;
  localparam logic [15:0] CLE_CRC_INIT   = 16'hFFFF;
  localparam int unsigned CLE_BYTE_W     = 8;
  localparam int unsigned CLE_BUF_DEPTH  = 2;

  typedef enum logic [2:0] {
    CLE_IDLE   = 3'b000,
    CLE_DATA   = 3'b001,
    CLE_CHECK  = 3'b010,
    CLE_HALT   = 3'b011,
    CLE_SUPPLY = 3'b100
  } cle_state_t;
endpackage
`default_nettype wire

//--- dv/cle_loader_chk.sv
// Checker of the loader's status, frame and byte outputs
`default_nettype none
module cle_loader_chk (
  input wire logic       CLK, RESET, CONFIG_REQ_N, SUPPLY_OK, STATUS_OE, BYTE_VALID,
  input wire logic       BYTE_READY, CRC_ERROR, SUPPLY_ERROR, FRAME_DONE, LOADING,
  input wire logic [7:0] BYTE_DATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_crc_oe: assert property (CRC_ERROR |-> STATUS_OE) else $error("crc oe");
  a_crc_hold: assert property ($rose(CRC_ERROR) && CONFIG_REQ_N |=> CRC_ERROR [*8])
    else $error("crc hold");
  a_sup_oe: assert property (SUPPLY_ERROR |-> STATUS_OE) else $error("sup oe");
  a_sup_fail: assert property ($fell(SUPPLY_OK) |-> ##[1:4] SUPPLY_ERROR) else $error("sup");
  a_halt_quiet: assert property (CRC_ERROR |-> !LOADING && !FRAME_DONE) else $error("halt");
  a_done_pulse: assert property (FRAME_DONE |=> !FRAME_DONE) else $error("done");
  a_done_ok: assert property (FRAME_DONE |-> !STATUS_OE && !CRC_ERROR) else $error("ok");
  a_byte_hold: assert property (BYTE_VALID && !BYTE_READY |=> BYTE_VALID && $stable(BYTE_DATA))
    else $error("byte");
endmodule
bind cle_loader cle_loader_chk u_chk (.CLK, .RESET, .CONFIG_REQ_N, .SUPPLY_OK, .STATUS_OE,
  .BYTE_VALID, .BYTE_READY, .CRC_ERROR, .SUPPLY_ERROR, .FRAME_DONE, .LOADING, .BYTE_DATA);
`default_nettype wire

//--- dv/cle_host_model.sv
// Host model that shifts configuration words into the loader
`default_nettype none
module cle_host_model (
  input  wire logic CLK,
  input  wire logic oe,
  output logic      dclk,
  output logic      data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial dclk = 0;
  initial data = 0;
  // LSB first; low status resets the read-out unless brk
  task automatic send(input logic [31:0] w, input int hp, input bit brk);
    for (int i = 0; i < 32 && (brk || !oe); i++) begin
      @(posedge CLK);
      data <= w[i];
      repeat (hp - 1) @(posedge CLK);
      dclk <= 1;
      repeat (hp) @(posedge CLK);
      dclk <= 0;
      data <= ~w[i];
    end
  endtask
endmodule
`default_nettype wire

//--- dv/test_cle_loader.sv
// Self-checking bench of the configuration loader
`default_nettype none
module test_cle_loader import cle_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, req_n, act, sup, rdy, oe, bv, ce, se, fd, ld, dclk, din;
  logic [7:0] bd;
  logic [7:0] q[$];
  int         error_cnt, tests_run, dn;
  cle_loader #(.FRAME_BITS(16)) uut (.CLK(clk), .RESET(rst), .DCLK_IN(dclk), .DATA_IN(din),
    .CONFIG_REQ_N(req_n), .ACTIVE_SCHEME(act), .SUPPLY_OK(sup), .STATUS_IN(!oe), .STATUS_OUT(),
    .STATUS_OE(oe), .BYTE_DATA(bd), .BYTE_VALID(bv), .BYTE_READY(rdy), .CRC_ERROR(ce),
    .SUPPLY_ERROR(se), .FRAME_DONE(fd), .LOADING(ld));
  cle_host_model host (.CLK(clk), .oe(oe), .dclk(dclk), .data(din));
  always @(posedge clk) begin
    if (bv && rdy) q.push_back(bd);
    if (fd) dn++;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // Data word with its check value behind it
  function automatic logic [31:0] frm(input logic [15:0] d);
    logic [15:0] c;
    c = CLE_CRC_INIT;
    for (int i = 0; i < 16; i++) c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? CLE_CRC_POLY : 16'h0000);
    return {c, d};
  endfunction
  task automatic go(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    req_n <= 0;
    go(6);
    req_n <= 1;
    go(6);
    q = {};
    dn = 0;
  endtask
  task automatic t_good();
    start();
    rdy <= 0;
    host.send(frm(16'hA185), 6, 0);
    go(8);
    chk({16'(q.size()), 16'(dn)}, 1);
    rdy <= 1;
    go(4);
    chk({q[1], q[0], 15'h0000, oe}, 32'hA185_0000);
    $display("good frame done");
  endtask
  task automatic t_bad();
    start();
    host.send(frm(16'h3C5A) ^ 32'h0001_0000, 3, 0);
    go(8);
    chk({oe, ce, ld}, 6);
    host.send(frm(16'h3C5A), 3, 1);
    go(8);
    chk({16'(q.size()), 13'h0000, oe, ce, ld}, 32'h0002_0006);
    start();
    chk({oe, ce, ld}, 1);
    $display("bad frame done");
  endtask
  task automatic t_sup();
    sup <= 0;
    go(6);
    chk({se, oe}, 3);
    sup <= 1;
    go(6);
    chk({oe, ld}, 2);
    act <= 1;
    sup <= 0;
    go(6);
    sup <= 1;
    go(8);
    chk({oe, ld}, 1);
    $display("supply done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20us;
    error_cnt++;
    print_verdict();
  end
  initial begin
    {rst, req_n, sup, rdy, act} = 5'b11110;
    go(2);
    rst <= 0;
    go(3);
    t_good();
    t_bad();
    t_sup();
    print_verdict();
  end
endmodule
`default_nettype wire
